//--- dv/can_bus_model.sv
`timescale 1ns/1ps
module can_bus_model (
  // Clock and bus line
  input wire logic clk_sys,
  input wire logic bus_level,
  // Toward the block
  output logic [2:0] sample_taps,
  output logic bus_activity,
  output logic recessive_run_done
);
  logic [1:0] taps_q;
  logic [3:0] run_q;
  assign sample_taps = {taps_q, bus_level};
  // Recessive to dominant edge counts as bus activity
  assign bus_activity = taps_q[0] & ~bus_level;
  assign recessive_run_done = bus_level & (run_q == 4'ha);
  always_ff @(posedge clk_sys) begin
    taps_q <= {taps_q[0], bus_level};
  end
  always_ff @(posedge clk_sys) begin
    run_q <= (!bus_level || recessive_run_done) ? 4'h0 : run_q + 4'h1;
  end
endmodule

//--- dv/can_status_checker.sv
`timescale 1ns/1ps
module can_status_checker (
  // Clock, reset, bus
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Engine side
  input wire logic rx_message_ok,
  input wire logic [2:0] sample_taps,
  input wire logic soft_reset_control,
  input wire logic [3:0] time_segment_one,
  input wire logic [2:0] time_segment_two,
  input wire logic triple_sample_select,
  input wire logic [4:0] quanta_per_bit,
  input wire logic sampled_bit,
  input wire logic buffer_exchange_ok,
  input wire logic engine_abort,
  // Interrupts
  input wire logic wakeup_irq,
  input wire logic error_irq,
  input wire logic receive_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic maj;
  assign maj = (sample_taps[0] & sample_taps[1]) | (sample_taps[1] & sample_taps[2]) | (sample_taps[0] & sample_taps[2]);
  property p_single; !triple_sample_select |=> sampled_bit == $past(sample_taps[0]); endproperty
  property p_triple; triple_sample_select |=> sampled_bit == $past(maj); endproperty
  property p_quanta; quanta_per_bit == 5'(time_segment_one) + 5'(time_segment_two) + 5'h3; endproperty
  property p_lock;
    !soft_reset_control |=> $stable({triple_sample_select, time_segment_two, time_segment_one});
  endproperty
  property p_abort; engine_abort == soft_reset_control; endproperty
  property p_hold; soft_reset_control && $past(soft_reset_control) |-> !(wakeup_irq | error_irq | receive_irq); endproperty
  property p_full;
    rx_message_ok && !soft_reset_control && !(psel && penable && pwrite) |=> !buffer_exchange_ok;
  endproperty
  property p_keep;
    !buffer_exchange_ok && !soft_reset_control && !(psel && penable && pwrite) |=> !buffer_exchange_ok;
  endproperty
  a_single: assert property (p_single) else $error("single sample mismatch");
  a_triple: assert property (p_triple) else $error("majority sample mismatch");
  a_quanta: assert property (p_quanta) else $error("quanta per bit wrong");
  a_lock: assert property (p_lock) else $error("bit timing changed outside soft reset");
  a_abort: assert property (p_abort) else $error("engine abort not following soft reset");
  a_hold: assert property (p_hold) else $error("interrupt during soft reset");
  a_full: assert property (p_full) else $error("full flag not set");
  a_keep: assert property (p_keep) else $error("full flag dropped without clear");
  c_triple: cover property (triple_sample_select && maj != sample_taps[0]);
  c_full: cover property ($fell(buffer_exchange_ok));
  c_err: cover property ($rose(error_irq));
endmodule

bind can_bit_timing_and_status_flags can_status_checker u_chk (.clk_sys(clk_sys), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .rx_message_ok(rx_message_ok), .sample_taps(sample_taps),
  .soft_reset_control(soft_reset_control), .time_segment_one(time_segment_one),
  .time_segment_two(time_segment_two), .triple_sample_select(triple_sample_select),
  .quanta_per_bit(quanta_per_bit), .sampled_bit(sampled_bit), .buffer_exchange_ok(buffer_exchange_ok),
  .engine_abort(engine_abort), .wakeup_irq(wakeup_irq), .error_irq(error_irq), .receive_irq(receive_irq));

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  localparam logic [11:0] srs = can_status_pkg::addr_soft_reset;
  localparam logic [11:0] btr = can_status_pkg::addr_bit_timing;
  localparam logic [11:0] flg = can_status_pkg::addr_rx_flags;
  localparam logic [11:0] ien = can_status_pkg::addr_rx_irq_en;
  localparam logic [11:0] txf = can_status_pkg::addr_tx_flags;
  localparam logic [11:0] sts = can_status_pkg::addr_status;
  logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bus_level = 1'b0;
  logic sleep_mode = 1'b0, rx_message_ok = 1'b0, rx_overrun = 1'b0, bus_activity, recessive_run_done;
  logic pready, pslverr, wakeup_irq, error_irq, receive_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [2:0] tx_sent = 3'h0, tx_aborted = 3'h0, sample_taps;
  logic transmit_irq;
  logic [8:0] receive_error_count = 9'h000, transmit_error_count = 9'h000;
  int miscompares = 0, num_checks = 0;
  always #2 clk_sys = ~clk_sys;
  can_bus_model u_bus (.clk_sys(clk_sys), .bus_level(bus_level), .sample_taps(sample_taps),
    .bus_activity(bus_activity), .recessive_run_done(recessive_run_done));
  can_bit_timing_and_status_flags DUT (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .bus_activity(bus_activity), .rx_message_ok(rx_message_ok),
    .rx_overrun(rx_overrun), .recessive_run_done(recessive_run_done), .tx_sent(tx_sent), .tx_aborted(tx_aborted),
    .receive_error_count(receive_error_count), .transmit_error_count(transmit_error_count),
    .sample_taps(sample_taps), .soft_reset_control(), .time_segment_one(), .time_segment_two(),
    .triple_sample_select(), .quanta_per_bit(), .sampled_bit(), .buffer_exchange_ok(), .engine_abort(),
    .wakeup_irq(wakeup_irq), .error_irq(error_irq), .receive_irq(receive_irq), .transmit_irq(transmit_irq));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1) tick(1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 8'h00);
    `CHK(rdat, e)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tick(5000);
    miscompares++;
    results();
  end
  initial begin
    tick(10);
    srst <= 1'b0;
    tick(1);
    rd(flg, 32'h0);
    rd(ien, 32'h0);
    rd(txf, 32'h7);
    rd(srs, 32'h1);
    rd(12'hffc, 32'h0);
    $display("reset test done");
    wr(btr, 8'ha5);
    rd(btr, 32'ha5);
    rd(sts, 32'h0a01);
    wr(srs, 8'h00);
    wr(btr, 8'h3c);
    rd(btr, 32'ha5);
    $display("bit timing test done");
    wr(ien, 8'hff);
    rd(ien, 32'hff);
    rx_message_ok <= 1'b1;
    tick(1);
    rx_message_ok <= 1'b0;
    tick(1);
    `CHK(receive_irq, 1'b1)
    wr(flg, 8'h00);
    rd(flg, 32'h01);
    wr(flg, 8'h01);
    rd(flg, 32'h00);
    $display("receive full test done");
    receive_error_count <= 9'h061;
    tick(2);
    rd(flg, 32'h40);
    transmit_error_count <= 9'h064;
    tick(2);
    rd(flg, 32'h60);
    `CHK(error_irq, 1'b1)
    wr(flg, 8'h20);
    rd(flg, 32'h60);
    transmit_error_count <= 9'h080;
    tick(2);
    rd(flg, 32'h68);
    transmit_error_count <= 9'h100;
    tick(2);
    rd(flg, 32'h6c);
    transmit_error_count <= 9'h000;
    receive_error_count <= 9'h000;
    tick(2);
    wr(flg, 8'h7c);
    rd(flg, 32'h04);
    // Idle bus long enough for more than 128 recessive runs
    bus_level <= 1'b1;
    tick(1420);
    wr(flg, 8'h04);
    rd(flg, 32'h00);
    `CHK(error_irq, 1'b0)
    $display("error state test done");
    rx_overrun <= 1'b1;
    tick(1);
    rx_overrun <= 1'b0;
    tick(1);
    rd(flg, 32'h02);
    wr(flg, 8'h02);
    sleep_mode <= 1'b1;
    bus_level <= 1'b0;
    tick(2);
    sleep_mode <= 1'b0;
    rd(flg, 32'h80);
    `CHK(wakeup_irq, 1'b1)
    $display("overrun and wakeup test done");
    wr(txf, 8'h07);
    rd(txf, 32'h00);
    tx_sent <= 3'h2;
    tick(1);
    tx_sent <= 3'h0;
    tick(1);
    rd(txf, 32'h02);
    wr(can_status_pkg::addr_tx_ctrl, 8'h02);
    `CHK(transmit_irq, 1'b1)
    tx_aborted <= 3'h4;
    tick(1);
    tx_aborted <= 3'h0;
    tick(1);
    rd(txf, 32'h46);
    wr(txf, 8'h70);
    rd(txf, 32'h46);
    wr(srs, 8'h01);
    rd(flg, 32'h00);
    rd(ien, 32'h00);
    rd(txf, 32'h07);
    $display("transmit and soft reset test done");
    results();
  end
endmodule

//--- hdl/can_bit_timing_and_status_flags.sv
`timescale 1ns/1ps
module can_bit_timing_and_status_flags (
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol engine side
  input wire logic sleep_mode,
  input wire logic bus_activity,
  input wire logic rx_message_ok,
  input wire logic rx_overrun,
  input wire logic recessive_run_done,
  input wire logic [2:0] tx_sent,
  input wire logic [2:0] tx_aborted,
  input wire logic [8:0] receive_error_count,
  input wire logic [8:0] transmit_error_count,
  input wire logic [2:0] sample_taps,
  // Engine controls and status
  output logic soft_reset_control,
  output logic [3:0] time_segment_one,
  output logic [2:0] time_segment_two,
  output logic triple_sample_select,
  output logic [4:0] quanta_per_bit,
  output logic sampled_bit,
  output logic buffer_exchange_ok,
  output logic engine_abort,
  // Interrupt requests
  output logic wakeup_irq,
  output logic error_irq,
  output logic receive_irq,
  output logic transmit_irq
);

  can_status_pkg::apb_req_t req;
  can_status_pkg::bit_timing_t bt_q;
  logic [7:0] rx_flags_q;
  logic [7:0] rx_flags_d;
  logic [7:0] rx_ie_q;
  logic [2:0] tx_empty_q;
  logic [2:0] tx_abort_q;
  logic [2:0] tx_ie_q;
  logic [7:0] recovery_q;
  logic soft_reset_q;
  logic [7:0] rx_cause;
  logic [7:0] rx_clear;
  logic [7:0] rx_set;
  logic wr;
  logic rd;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  assign req.paddr_ok = hit(paddr, can_status_pkg::addr_soft_reset) | hit(paddr, can_status_pkg::addr_bit_timing)
    | hit(paddr, can_status_pkg::addr_rx_flags) | hit(paddr, can_status_pkg::addr_rx_irq_en)
    | hit(paddr, can_status_pkg::addr_tx_flags) | hit(paddr, can_status_pkg::addr_tx_ctrl)
    | hit(paddr, can_status_pkg::addr_err_count) | hit(paddr, can_status_pkg::addr_status);
  assign req.paddr = paddr;
  assign req.pwrite = pwrite;
  assign req.pwdata = pwdata;

  // Zero wait states: every access completes in its first access cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~req.paddr_ok;
  assign wr = psel & penable & req.pwrite & req.paddr_ok;
  assign rd = psel & ~penable & ~req.pwrite;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      soft_reset_q <= 1'b1;
    end else if (wr && hit(req.paddr, can_status_pkg::addr_soft_reset)) begin
      soft_reset_q <= req.pwdata[0];
    end
  end
  assign soft_reset_control = soft_reset_q;
  assign engine_abort = soft_reset_q;

  // Timing stays put outside soft reset so a live bit is never reshaped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bt_q <= can_status_pkg::bt_reset;
    end else if (wr && soft_reset_q && hit(req.paddr, can_status_pkg::addr_bit_timing)) begin
      bt_q <= req.pwdata[7:0];
    end
  end
  assign triple_sample_select = bt_q.triple_sample_select;
  assign time_segment_one = bt_q.time_segment_one;
  assign time_segment_two = bt_q.time_segment_two;
  // Sync quantum plus both segments; codes are length minus one
  assign quanta_per_bit = 5'd1 + {1'b0, bt_q.time_segment_one} + 5'd1 + {2'b00, bt_q.time_segment_two} + 5'd1;

  // taps[0] is the sample point, taps[2:1] the two quanta before it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sampled_bit <= 1'b1;
    end else if (bt_q.triple_sample_select) begin
      sampled_bit <= majority(sample_taps);
    end else begin
      sampled_bit <= sample_taps[0];
    end
  end

  // Bus-off recovery: count runs of recessive bits, counter cleared while the bus-off flag is clear
  always_ff @(posedge clk_sys) begin
    if (srst || !rx_flags_q[can_status_pkg::rxf_bus_off]) begin
      recovery_q <= 8'h00;
    end else if (recessive_run_done && recovery_q != can_status_pkg::recovery_count) begin
      recovery_q <= recovery_q + 8'h01;
    end
  end

  // Live conditions behind each receiver flag
  always_comb begin
    rx_cause = 8'h00;
    rx_cause[can_status_pkg::rxf_bus_off] = transmit_error_count > can_status_pkg::bus_off_level;
    rx_cause[can_status_pkg::rxf_rx_passive] = (receive_error_count > can_status_pkg::passive_level)
      & ~rx_cause[can_status_pkg::rxf_bus_off];
    rx_cause[can_status_pkg::rxf_tx_passive] = (transmit_error_count > can_status_pkg::passive_level)
      & ~rx_cause[can_status_pkg::rxf_bus_off];
    rx_cause[can_status_pkg::rxf_rx_warn] = (receive_error_count > can_status_pkg::warn_level)
      & ~rx_flags_q[can_status_pkg::rxf_rx_passive] & ~rx_flags_q[can_status_pkg::rxf_tx_passive]
      & ~rx_flags_q[can_status_pkg::rxf_bus_off];
    rx_cause[can_status_pkg::rxf_tx_warn] = (transmit_error_count > can_status_pkg::warn_level)
      & ~rx_flags_q[can_status_pkg::rxf_rx_passive] & ~rx_flags_q[can_status_pkg::rxf_tx_passive]
      & ~rx_flags_q[can_status_pkg::rxf_bus_off];
    rx_cause[can_status_pkg::rxf_wakeup] = sleep_mode & bus_activity;
    rx_cause[can_status_pkg::rxf_overrun] = rx_overrun;
    rx_cause[can_status_pkg::rxf_full] = rx_message_ok & ~rx_flags_q[can_status_pkg::rxf_full];
  end

  always_comb begin
    rx_set = rx_cause;
    rx_clear = 8'h00;
    if (wr && hit(req.paddr, can_status_pkg::addr_rx_flags)) begin
      rx_clear = req.pwdata[7:0] & ~rx_cause;
    end
    // Outside soft reset, bus off holds until the full recovery sequence is seen
    if (recovery_q != can_status_pkg::recovery_count) begin
      rx_clear[can_status_pkg::rxf_bus_off] = 1'b0;
    end
    rx_flags_d = (rx_flags_q & ~rx_clear) | rx_set;
  end

  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset_q) begin
      rx_flags_q <= can_status_pkg::reset_byte;
    end else begin
      rx_flags_q <= rx_flags_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset_q) begin
      rx_ie_q <= can_status_pkg::reset_byte;
    end else if (wr && hit(req.paddr, can_status_pkg::addr_rx_irq_en)) begin
      rx_ie_q <= req.pwdata[7:0];
    end
  end

  // Exchange into the foreground buffer is blocked while full
  assign buffer_exchange_ok = ~rx_flags_q[can_status_pkg::rxf_full];

  // Transmitter empties: set on send or abort, which wins over a clear
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset_q) begin
      tx_empty_q <= can_status_pkg::tx_empty_reset[2:0];
      tx_abort_q <= 3'b000;
    end else begin
      for (int i = 0; i < can_status_pkg::tx_buffers; i++) begin
        if (tx_sent[i] || tx_aborted[i]) begin
          tx_empty_q[i] <= 1'b1;
          tx_abort_q[i] <= tx_aborted[i];
        end else if (wr && hit(req.paddr, can_status_pkg::addr_tx_flags) && req.pwdata[i]) begin
          tx_empty_q[i] <= 1'b0;
          tx_abort_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset_q) begin
      tx_ie_q <= 3'b000;
    end else if (wr && hit(req.paddr, can_status_pkg::addr_tx_ctrl)) begin
      tx_ie_q <= req.pwdata[2:0];
    end
  end

  // Request lines follow flags directly so a clear drops them next cycle
  assign wakeup_irq = rx_flags_q[can_status_pkg::rxf_wakeup] & rx_ie_q[can_status_pkg::rxf_wakeup];
  assign receive_irq = rx_flags_q[can_status_pkg::rxf_full] & rx_ie_q[can_status_pkg::rxf_full];
  assign error_irq = |(rx_flags_q[6:1] & rx_ie_q[6:1]);
  assign transmit_irq = |(tx_empty_q & tx_ie_q);

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (1'b1)
      hit(req.paddr, can_status_pkg::addr_soft_reset): rdata_d[0] = soft_reset_q;
      hit(req.paddr, can_status_pkg::addr_bit_timing): rdata_d[7:0] = bt_q;
      hit(req.paddr, can_status_pkg::addr_rx_flags): rdata_d[7:0] = rx_flags_q;
      hit(req.paddr, can_status_pkg::addr_rx_irq_en): rdata_d[7:0] = rx_ie_q;
      hit(req.paddr, can_status_pkg::addr_tx_flags): begin
        rdata_d[can_status_pkg::txf_abort_lsb +: 3] = tx_abort_q;
        rdata_d[2:0] = tx_empty_q;
      end
      hit(req.paddr, can_status_pkg::addr_tx_ctrl): rdata_d[2:0] = tx_ie_q;
      hit(req.paddr, can_status_pkg::addr_err_count): begin
        rdata_d[24:16] = transmit_error_count;
        rdata_d[8:0] = receive_error_count;
      end
      hit(req.paddr, can_status_pkg::addr_status): begin
        rdata_d[12:8] = quanta_per_bit;
        rdata_d[0] = buffer_exchange_ok;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup so it is registered during access
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= rdata_d;
    end
  end

endmodule

//--- pkg/can_status_pkg.sv
package can_status_pkg;

  // Register byte addresses (word aligned)
  localparam logic [11:0] addr_soft_reset = 12'h000;
  localparam logic [11:0] addr_bit_timing = 12'h004;
  localparam logic [11:0] addr_rx_flags = 12'h008;
  localparam logic [11:0] addr_rx_irq_en = 12'h00c;
  localparam logic [11:0] addr_tx_flags = 12'h010;
  localparam logic [11:0] addr_tx_ctrl = 12'h014;
  localparam logic [11:0] addr_err_count = 12'h018;
  localparam logic [11:0] addr_status = 12'h01c;

  // Receiver flag bit positions
  localparam int rxf_wakeup = 7;
  localparam int rxf_rx_warn = 6;
  localparam int rxf_tx_warn = 5;
  localparam int rxf_rx_passive = 4;
  localparam int rxf_tx_passive = 3;
  localparam int rxf_bus_off = 2;
  localparam int rxf_overrun = 1;
  localparam int rxf_full = 0;

  // Transmitter flag layout: abort acks in 6:4, empties in 2:0
  localparam int txf_abort_lsb = 4;
  localparam int tx_buffers = 3;

  // Bit timing register layout
  localparam int bt_triple = 7;
  localparam int bt_seg2_lsb = 4;
  localparam int bt_seg1_lsb = 0;

  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [7:0] tx_empty_reset = 8'h07;
  localparam logic [7:0] bt_reset = 8'h00;

  // Error-state thresholds
  localparam logic [8:0] warn_level = 9'h060;
  localparam logic [8:0] passive_level = 9'h07f;
  localparam logic [8:0] bus_off_level = 9'h0ff;
  localparam logic [7:0] recovery_count = 8'h80;

  typedef struct packed {
    logic triple_sample_select;
    logic [2:0] time_segment_two;
    logic [3:0] time_segment_one;
  } bit_timing_t;

  typedef struct packed {
    logic paddr_ok;
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic wakeup;
    logic rx_message_ok;
    logic overrun;
    logic recessive_run;
    logic [2:0] tx_sent;
    logic [2:0] tx_aborted;
  } can_events_t;

endpackage
